//--- test_uoed_top.sv
// Testbench: descriptor records and OUT transactions of the endpoint block
`timescale 1ns/1ps
`default_nettype none
module test_uoed_top;
   logic        MCLK, RST, WR, RD, BUF_READY;
   logic [15:0] ADDR;
   logic [7:0]  WDATA, RDATA, RX_DATA, BUF_WDATA;
   logic        TOK_VALID, RX_VALID, RX_READY, RX_END, RX_CRC_OK, RX_PID_DATA1;
   logic [1:0]  TOK_EP, HS_CODE, XFER_EP, hs_code, done_ep;
   logic        HS_VALID, BUF_WE, XFER_DONE, XFER_IRQ, full_seen;
   logic [10:0] BUF_ADDR;
   logic [7:0]  mem [0:2047];
   int          fails, comparisons, hs_n, done_n, irq_n, wr_n;
   uoed_top u_uoed_top (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WR(WR), .RD(RD),
      .WDATA(WDATA), .RDATA(RDATA), .TOK_VALID(TOK_VALID), .TOK_EP(TOK_EP),
      .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_READY(RX_READY), .RX_END(RX_END),
      .RX_CRC_OK(RX_CRC_OK), .RX_PID_DATA1(RX_PID_DATA1), .HS_VALID(HS_VALID),
      .HS_CODE(HS_CODE), .BUF_WE(BUF_WE), .BUF_ADDR(BUF_ADDR), .BUF_WDATA(BUF_WDATA),
      .BUF_READY(BUF_READY), .XFER_DONE(XFER_DONE), .XFER_EP(XFER_EP), .XFER_IRQ(XFER_IRQ));
   uoed_host u_uoed_host (.MCLK(MCLK), .RX_READY(RX_READY), .TOK_VALID(TOK_VALID),
      .TOK_EP(TOK_EP), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_END(RX_END),
      .RX_CRC_OK(RX_CRC_OK), .RX_PID_DATA1(RX_PID_DATA1));
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      if (HS_VALID === 1'b1) begin hs_n++; hs_code = HS_CODE; end
      if (XFER_DONE === 1'b1) begin done_n++; done_ep = XFER_EP; end
      if (XFER_IRQ === 1'b1) irq_n++;
      if (RX_READY === 1'b0) full_seen = 1'b1;
      if (BUF_WE === 1'b1 && BUF_READY) begin mem[BUF_ADDR] = BUF_WDATA; wr_n++; end
   end
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_cnt(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         fails++;
         $display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge MCLK);
      ADDR = a; WDATA = d; WR = 1'b1;
      @(negedge MCLK);
      WR = 1'b0;
   endtask : wr
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      @(negedge MCLK);
      ADDR = a; RD = 1'b1;
      @(negedge MCLK);
      RD = 1'b0;
      chk_byte(RDATA, exp);
   endtask : rchk
   function automatic logic [7:0] mask_of(input logic [15:0] a);
      if (a < 16'hff08 || a > 16'hff1f) return 8'h00;
      case (a[2:0])
         3'h0: return 8'hfc;
         3'h3, 3'h4: return 8'h00;
         3'h7: return 8'h7f;
         default: return 8'hff;
      endcase
   endfunction : mask_of
   task automatic xact(input logic [1:0] ep, input int len, input logic d1, input int st,
                       input int exp_hs, input logic [1:0] code, input int exp_done);
      int h0, d0, n;
      logic stuck;
      h0 = hs_n; d0 = done_n; wr_n = 0; full_seen = 1'b0; n = 0;
      if (st > 0) BUF_READY = 1'b0;
      fork
         u_uoed_host.send(ep, len, d1, stuck);
         begin repeat (st) @(negedge MCLK); BUF_READY = 1'b1; end
      join
      while (done_n == d0 && n < 60) begin @(negedge MCLK); n++; end
      if (stuck || (exp_done != 0 && done_n == d0)) begin
         fails++;
         $display("wrong value at %0t: transfer hung", $time);
         complete_run();
      end
      chk_cnt(hs_n - h0, exp_hs);
      if (exp_hs != 0) chk_byte(8'(hs_code), 8'(code));
      chk_cnt(done_n - d0, exp_done);
   endtask : xact
   task automatic t_reset;
      for (int a = 16'hff08; a < 16'hff20; a++) rchk(16'(a), 8'h00);
   endtask : t_reset
   task automatic t_masks;
      logic [7:0] d;
      for (int a = 16'hff07; a < 16'hff21; a++) begin
         d = (a[2:0] == 3'h0) ? 8'hbf : 8'hff;
         wr(16'(a), d);
         rchk(16'(a), d & mask_of(16'(a)));
         wr(16'(a), 8'h00);
      end
   endtask : t_masks
   task automatic t_recv_x;
      wr(16'hff09, 8'h10);
      wr(16'hff0f, 8'h40);
      wr(16'hff08, 8'h84);
      xact(2'h1, 64, 1'b0, 40, 1, 2'h0, 1);
      chk_byte(8'(full_seen), 8'h01);
      chk_cnt(wr_n, 64);
      for (int k = 0; k < 64; k++) chk_byte(mem[11'h080 + k], 8'(k * 3 + 1));
      rchk(16'hff0a, 8'hc0);
      rchk(16'hff08, 8'ha4);
      rchk(16'hff09, 8'h10);
      chk_cnt(irq_n, 1);
      chk_byte(8'(done_ep), 8'h01);
   endtask : t_recv_x
   task automatic t_nak;
      xact(2'h1, 4, 1'b1, 0, 1, 2'h1, 0);
      wr(16'hff0a, 8'h00);
      xact(2'h1, 4, 1'b0, 0, 1, 2'h0, 0);
      rchk(16'hff0a, 8'h00);
   endtask : t_nak
   task automatic t_double_buffer_enable_y;
      int i0;
      i0 = irq_n;
      wr(16'hff11, 8'h30);
      wr(16'hff15, 8'h20);
      wr(16'hff17, 8'h08);
      wr(16'hff10, 8'hb0);
      xact(2'h2, 5, 1'b1, 0, 1, 2'h0, 1);
      chk_cnt(wr_n, 5);
      for (int k = 0; k < 5; k++) chk_byte(mem[11'h100 + k], 8'(k * 3 + 2));
      rchk(16'hff16, 8'h85);
      rchk(16'hff12, 8'h00);
      rchk(16'hff10, 8'h90);
      chk_cnt(irq_n - i0, 0);
      chk_byte(8'(done_ep), 8'h02);
   endtask : t_double_buffer_enable_y
   task automatic t_refuse;
      wr(16'hff1f, 8'h40);
      wr(16'hff18, 8'h88);
      xact(2'h3, 2, 1'b0, 0, 1, 2'h2, 0);
      rchk(16'hff18, 8'h88);
      wr(16'hff18, 8'h00);
      xact(2'h3, 2, 1'b0, 0, 0, 2'h0, 0);
   endtask : t_refuse
   initial begin
      RST = 1'b1; WR = 1'b0; RD = 1'b0; ADDR = 16'h0000; WDATA = 8'h00;
      BUF_READY = 1'b1; full_seen = 1'b0;
      fails = 0; comparisons = 0; hs_n = 0; done_n = 0; irq_n = 0; wr_n = 0;
      repeat (4) @(negedge MCLK);
      RST = 1'b0;
      t_reset();
      t_masks();
      t_recv_x();
      t_nak();
      t_double_buffer_enable_y();
      t_refuse();
      complete_run();
   end
endmodule : test_uoed_top
`default_nettype wire

//--- uoed_bufwr.sv
// Module: writes received bytes into buffer RAM from the chosen base
`timescale 1ns/1ps
`default_nettype none
module uoed_bufwr (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire logic [7:0]  base,
   input  wire logic        mem_ready,
   uoed_strm_if.snk         in,
   output logic             mem_we,
   output logic [10:0]      mem_addr,
   output logic [7:0]       mem_data,
   output logic             busy
);
   logic [7:0]  base_q, base_d;
   logic [6:0]  ofs_q, ofs_d;
   logic        we_q, we_d;
   logic [10:0] addr_q, addr_d;
   logic [7:0]  data_q, data_d;
   logic        take;

   assign in.ready = !we_q || mem_ready;
   assign take     = in.valid && in.ready;
   assign mem_we   = we_q;
   assign mem_addr = addr_q;
   assign mem_data = data_q;
   assign busy     = we_q;

   always_comb begin
      base_d = base_q;
      ofs_d  = ofs_q;
      we_d   = we_q && !mem_ready;
      addr_d = addr_q;
      data_d = data_q;
      if (start) begin
         base_d = base;
         ofs_d  = '0;
      end
      if (take) begin
         we_d   = 1'b1;
         addr_d = {base_q, 3'b000} + 11'(ofs_q);
         data_d = in.data;
         ofs_d  = 7'(ofs_q + 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         base_q <= '0;
         ofs_q  <= '0;
         we_q   <= 1'b0;
         addr_q <= '0;
         data_q <= '0;
      end else begin
         base_q <= base_d;
         ofs_q  <= ofs_d;
         we_q   <= we_d;
         addr_q <= addr_d;
         data_q <= data_d;
      end
   end

   property p_first_addr;
      @(posedge clk) disable iff (rst)
      take && ofs_q == 7'h00 && !start |=> mem_we && mem_addr == {$past(base_q), 3'b000};
   endproperty
   a_first_addr: assert property (p_first_addr)
      else $error("first byte not written at the base address");
   property p_hold_write;
      @(posedge clk) disable iff (rst)
      mem_we && !mem_ready |=> mem_we && $stable(mem_addr) && $stable(mem_data);
   endproperty
   a_hold_write: assert property (p_hold_write)
      else $error("stalled write changed");
endmodule : uoed_bufwr
`default_nettype wire

//--- uoed_fifo.sv
// Module: parameterised FIFO, plain fill side, stream drain side
`timescale 1ns/1ps
`default_nettype none
module uoed_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   uoed_strm_if.src          out
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [W-1:0]  mem_d [D];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out.valid = (cnt_q != '0);
   assign out.data  = mem_q[rp_q];
   assign push      = in_valid && in_ready;
   assign pop       = out.valid && out.ready;

   always_comb begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wp_q] = in_data;
         wp_d        = (wp_q == AW'(D-1)) ? '0 : AW'(wp_q + 1'b1);
      end
      if (pop) begin
         rp_d = (rp_q == AW'(D-1)) ? '0 : AW'(rp_q + 1'b1);
      end
      if (push && !pop) begin
         cnt_d = (AW+1)'(cnt_q + 1'b1);
      end else if (pop && !push) begin
         cnt_d = (AW+1)'(cnt_q - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      mem_q <= mem_d;
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   property p_no_overrun;
      @(posedge clk) disable iff (rst)
      cnt_q == (AW+1)'(D) |=> cnt_q <= (AW+1)'(D);
   endproperty
   a_no_overrun: assert property (p_no_overrun)
      else $error("fifo count passed its depth");
   c_fifo_full: cover property (@(posedge clk) disable iff (rst) !in_ready);
endmodule : uoed_fifo
`default_nettype wire

//--- uoed_host.sv
// Host model: OUT token, data bytes and end of packet
`timescale 1ns/1ps
`default_nettype none
module uoed_host (
   input  wire logic       MCLK,
   input  wire logic       RX_READY,
   output logic            TOK_VALID,
   output logic      [1:0] TOK_EP,
   output logic            RX_VALID,
   output logic      [7:0] RX_DATA,
   output logic            RX_END,
   output logic            RX_CRC_OK,
   output logic            RX_PID_DATA1
);
   initial begin
      TOK_VALID = 1'b0;
      TOK_EP = 2'h0;
      RX_VALID = 1'b0;
      RX_DATA = 8'h00;
      RX_END = 1'b0;
      RX_CRC_OK = 1'b0;
      RX_PID_DATA1 = 1'b0;
   end
   task automatic send(input logic [1:0] ep, input int len, input logic d1,
                       output logic stuck);
      int n;
      stuck = 1'b0;
      @(negedge MCLK);
      TOK_VALID = 1'b1;
      TOK_EP = ep;
      @(negedge MCLK);
      TOK_VALID = 1'b0;
      TOK_EP = ~ep;
      for (int k = 0; k < len && k < 64; k++) begin
         RX_VALID = 1'b1;
         RX_DATA = 8'(k * 3 + ep);
         n = 0;
         // Ready settles from registered state before the taking edge
         #1;
         while (RX_READY !== 1'b1 && n < 200) begin
            @(negedge MCLK);
            #1;
            n++;
         end
         if (n == 200) stuck = 1'b1;
         @(negedge MCLK);
      end
      RX_VALID = 1'b0;
      RX_DATA = ~RX_DATA;
      RX_END = 1'b1;
      RX_CRC_OK = 1'b1;
      RX_PID_DATA1 = d1;
      @(negedge MCLK);
      RX_END = 1'b0;
      RX_CRC_OK = 1'b0;
      RX_PID_DATA1 = ~d1;
   endtask : send
endmodule : uoed_host
`default_nettype wire

//--- uoed_pkg.sv
// Package: descriptor map, field layout, reset values and state codes
package uoed_pkg;
   localparam int          EP_COUNT    = 3;
   localparam int          REC_BYTES   = 8;
   localparam logic [15:0] REC_BASE    = 16'hff08;
   localparam logic [15:0] REC_LAST    = 16'hff1f;
   localparam logic [2:0]  OFS_CFG     = 3'h0;
   localparam logic [2:0]  OFS_XBASE   = 3'h1;
   localparam logic [2:0]  OFS_XCNT    = 3'h2;
   localparam logic [2:0]  OFS_SPARE_A = 3'h3;
   localparam logic [2:0]  OFS_SPARE_B = 3'h4;
   localparam logic [2:0]  OFS_YBASE   = 3'h5;
   localparam logic [2:0]  OFS_YCNT    = 3'h6;
   localparam logic [2:0]  OFS_SIZE    = 3'h7;
   localparam int          BIT_BM_EN   = 7;
   localparam int          BIT_ISO     = 6;
   localparam int          BIT_TOGGLE  = 5;
   localparam int          BIT_DOUBLE_BUFFER_ENABLE    = 4;
   localparam int          BIT_STALL   = 3;
   localparam int          BIT_IRQ_EN  = 2;
   localparam int          BIT_NAK     = 7;
   localparam logic [7:0]  MASK_CFG    = 8'hfc;
   localparam logic [7:0]  MASK_SPARE  = 8'h00;
   localparam logic [7:0]  MASK_SIZE   = 8'h7f;
   localparam logic [7:0]  MASK_FULL   = 8'hff;
   localparam logic [7:0]  REC_RESET   = 8'h00;
   localparam logic [7:0]  MAX_COUNT   = 8'h40;
   localparam int          FIFO_WIDTH  = 8;
   localparam int          FIFO_DEPTH  = 8;
   localparam logic [1:0]  HS_ACK      = 2'h0;
   localparam logic [1:0]  HS_NAK      = 2'h1;
   localparam logic [1:0]  HS_STALL    = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RECV  = 3'b010,
      ST_DRAIN = 3'b100
   } uoed_state_t;
endpackage : uoed_pkg

//--- uoed_strm_if.sv
// Interface: byte stream between the receive FIFO and the buffer writer
`timescale 1ns/1ps
`default_nettype none
interface uoed_strm_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : uoed_strm_if
`default_nettype wire

//--- uoed_top.sv
// Module: output endpoint 1-3 descriptor records and OUT transaction control
`timescale 1ns/1ps
`default_nettype none
module uoed_top (
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic [15:0] ADDR,
   input  wire logic        WR,
   input  wire logic        RD,
   input  wire logic [7:0]  WDATA,
   output logic      [7:0]  RDATA,
   input  wire logic        TOK_VALID,
   input  wire logic [1:0]  TOK_EP,
   input  wire logic        RX_VALID,
   input  wire logic [7:0]  RX_DATA,
   output logic             RX_READY,
   input  wire logic        RX_END,
   input  wire logic        RX_CRC_OK,
   input  wire logic        RX_PID_DATA1,
   output logic             HS_VALID,
   output logic      [1:0]  HS_CODE,
   output logic             BUF_WE,
   output logic      [10:0] BUF_ADDR,
   output logic      [7:0]  BUF_WDATA,
   input  wire logic        BUF_READY,
   output logic             XFER_DONE,
   output logic      [1:0]  XFER_EP,
   output logic             XFER_IRQ
);
   logic [7:0]  rec_q [uoed_pkg::EP_COUNT][uoed_pkg::REC_BYTES];
   logic [7:0]  rec_d [uoed_pkg::EP_COUNT][uoed_pkg::REC_BYTES];
   logic [7:0]  rdata_q, rdata_d;
   uoed_pkg::uoed_state_t st_q, st_d;
   logic [1:0]  ep_q, ep_d;
   logic        accept_q, accept_d;
   logic        stall_q, stall_d;
   logic        sel_y_q, sel_y_d;
   logic [7:0]  cnt_q, cnt_d;
   logic [6:0]  limit_q, limit_d;
   logic        hs_v_q, hs_v_d;
   logic [1:0]  hs_c_q, hs_c_d;
   logic        done_q, done_d;
   logic        irq_q, irq_d;
   logic        done_now;
   logic [1:0]  tok_idx, cur_idx;
   logic        tok_ok;
   logic        push_ok, fifo_in_ready, fifo_push, wr_start, wr_busy;
   logic [7:0]  wr_base;
   logic        rx_take;

   uoed_strm_if #(.W(uoed_pkg::FIFO_WIDTH)) strm ();

   // Address decode, shared by read and write
   function automatic logic rec_hit(input logic [15:0] a);
      return a >= uoed_pkg::REC_BASE && a <= uoed_pkg::REC_LAST;
   endfunction : rec_hit

   function automatic logic [1:0] rec_ep(input logic [15:0] a);
      return 2'(a[4:3] - 2'h1);
   endfunction : rec_ep

   function automatic logic [7:0] rec_mask(input logic [2:0] ofs);
      case (ofs)
         uoed_pkg::OFS_CFG:     return uoed_pkg::MASK_CFG;
         uoed_pkg::OFS_SPARE_A: return uoed_pkg::MASK_SPARE;
         uoed_pkg::OFS_SPARE_B: return uoed_pkg::MASK_SPARE;
         uoed_pkg::OFS_SIZE:    return uoed_pkg::MASK_SIZE;
         default:               return uoed_pkg::MASK_FULL;
      endcase
   endfunction : rec_mask

   assign tok_idx  = 2'(TOK_EP - 2'h1);
   assign cur_idx  = 2'(ep_q - 2'h1);
   assign tok_ok   = TOK_VALID && |TOK_EP && st_q == uoed_pkg::ST_IDLE && !strm.valid && !wr_busy;
   assign push_ok  = accept_q && (cnt_q < {1'b0, limit_q});
   assign RX_READY = (st_q == uoed_pkg::ST_RECV) && push_ok ? fifo_in_ready : 1'b1;
   assign rx_take  = (st_q == uoed_pkg::ST_RECV) && RX_VALID && RX_READY;
   assign fifo_push = rx_take && push_ok;
   assign done_now = (st_q == uoed_pkg::ST_DRAIN) && !strm.valid && !wr_busy;

   always_comb begin
      logic [7:0] cfg;
      logic       sy;
      cfg      = rec_q[tok_idx][uoed_pkg::OFS_CFG];
      // Y only when double buffering is on
      sy       = cfg[uoed_pkg::BIT_DOUBLE_BUFFER_ENABLE] && cfg[uoed_pkg::BIT_TOGGLE];
      st_d     = st_q;
      ep_d     = ep_q;
      accept_d = accept_q;
      stall_d  = stall_q;
      sel_y_d  = sel_y_q;
      cnt_d    = cnt_q;
      limit_d  = limit_q;
      hs_v_d   = 1'b0;
      hs_c_d   = hs_c_q;
      wr_start = 1'b0;
      wr_base  = sy ? rec_q[tok_idx][uoed_pkg::OFS_YBASE] : rec_q[tok_idx][uoed_pkg::OFS_XBASE];
      case (st_q)
         uoed_pkg::ST_IDLE: begin
            if (tok_ok && cfg[uoed_pkg::BIT_BM_EN]) begin
               st_d     = uoed_pkg::ST_RECV;
               ep_d     = TOK_EP;
               sel_y_d  = sy;
               stall_d  = cfg[uoed_pkg::BIT_STALL];
               accept_d = !cfg[uoed_pkg::BIT_STALL] &&
                          !rec_q[tok_idx][sy ? uoed_pkg::OFS_YCNT : uoed_pkg::OFS_XCNT][uoed_pkg::BIT_NAK];
               cnt_d    = '0;
               limit_d  = rec_q[tok_idx][uoed_pkg::OFS_SIZE][6:0];
               // Base sampled as the start address
               wr_start = 1'b1;
            end
         end
         uoed_pkg::ST_RECV: begin
            if (rx_take && cnt_q != 8'hff) begin
               cnt_d = 8'(cnt_q + 1'b1);
            end
            if (RX_END) begin
               st_d = uoed_pkg::ST_IDLE;
               if (RX_CRC_OK) begin
                  if (stall_q) begin
                     hs_v_d = 1'b1;
                     hs_c_d = uoed_pkg::HS_STALL;
                  end else if (!accept_q) begin
                     hs_v_d = 1'b1;
                     hs_c_d = uoed_pkg::HS_NAK;
                  end else if (RX_PID_DATA1 != rec_q[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_TOGGLE]) begin
                     // Repeat packet: ACK again, keep state
                     hs_v_d = 1'b1;
                     hs_c_d = uoed_pkg::HS_ACK;
                  end else if (cnt_d <= {1'b0, limit_q}) begin
                     hs_v_d = 1'b1;
                     hs_c_d = uoed_pkg::HS_ACK;
                     st_d   = uoed_pkg::ST_DRAIN;
                  end
               end
            end
         end
         uoed_pkg::ST_DRAIN: begin
            if (done_now) begin
               st_d = uoed_pkg::ST_IDLE;
            end
         end
         default: st_d = uoed_pkg::ST_IDLE;
      endcase
   end

   // Software write first, hardware update after it, so the set wins
   always_comb begin
      logic [2:0] cofs;
      rec_d   = rec_q;
      rdata_d = rdata_q;
      done_d  = 1'b0;
      irq_d   = 1'b0;
      cofs    = sel_y_q ? uoed_pkg::OFS_YCNT : uoed_pkg::OFS_XCNT;
      if (RD && rec_hit(ADDR)) begin
         rdata_d = rec_q[rec_ep(ADDR)][ADDR[2:0]] & rec_mask(ADDR[2:0]);
      end else if (RD) begin
         rdata_d = 8'h00;
      end
      if (WR && rec_hit(ADDR)) begin
         rec_d[rec_ep(ADDR)][ADDR[2:0]] = WDATA & rec_mask(ADDR[2:0]);
      end
      if (done_now) begin
         rec_d[cur_idx][cofs] = {1'b1, cnt_q[6:0]};
         rec_d[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_TOGGLE] =
            !rec_q[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_TOGGLE];
         done_d = 1'b1;
         irq_d  = rec_q[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_IRQ_EN];
      end
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         for (int e = 0; e < uoed_pkg::EP_COUNT; e++) begin
            for (int b = 0; b < uoed_pkg::REC_BYTES; b++) begin
               // Stall and all other bits start low
               rec_q[e][b] <= uoed_pkg::REC_RESET;
            end
         end
         rdata_q  <= '0;
         st_q     <= uoed_pkg::ST_IDLE;
         ep_q     <= '0;
         accept_q <= 1'b0;
         stall_q  <= 1'b0;
         sel_y_q  <= 1'b0;
         cnt_q    <= '0;
         limit_q  <= '0;
         hs_v_q   <= 1'b0;
         hs_c_q   <= uoed_pkg::HS_ACK;
         done_q   <= 1'b0;
         irq_q    <= 1'b0;
      end else begin
         rec_q    <= rec_d;
         rdata_q  <= rdata_d;
         st_q     <= st_d;
         ep_q     <= ep_d;
         accept_q <= accept_d;
         stall_q  <= stall_d;
         sel_y_q  <= sel_y_d;
         cnt_q    <= cnt_d;
         limit_q  <= limit_d;
         hs_v_q   <= hs_v_d;
         hs_c_q   <= hs_c_d;
         done_q   <= done_d;
         irq_q    <= irq_d;
      end
   end

   assign RDATA     = rdata_q;
   assign HS_VALID  = hs_v_q;
   assign HS_CODE   = hs_c_q;
   assign XFER_DONE = done_q;
   assign XFER_EP   = ep_q;
   assign XFER_IRQ  = irq_q;

   uoed_fifo #(.W(uoed_pkg::FIFO_WIDTH), .D(uoed_pkg::FIFO_DEPTH)) u_fifo (
      .clk      (MCLK),
      .rst      (RST),
      .in_valid (fifo_push),
      .in_data  (RX_DATA),
      .in_ready (fifo_in_ready),
      .out      (strm.src)
   );

   uoed_bufwr u_wr (
      .clk       (MCLK),
      .rst       (RST),
      .start     (wr_start),
      .base      (wr_base),
      .mem_ready (BUF_READY),
      .in        (strm.snk),
      .mem_we    (BUF_WE),
      .mem_addr  (BUF_ADDR),
      .mem_data  (BUF_WDATA),
      .busy      (wr_busy)
   );

   property p_disabled;
      @(posedge MCLK) disable iff (RST)
      tok_ok && !rec_q[tok_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_BM_EN] |=> st_q == uoed_pkg::ST_IDLE;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled endpoint was serviced");
   property p_stall;
      @(posedge MCLK) disable iff (RST)
      st_q == uoed_pkg::ST_RECV && RX_END && RX_CRC_OK && stall_q
      |=> HS_VALID && HS_CODE == uoed_pkg::HS_STALL;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall not answered with STALL");
   property p_nak;
      @(posedge MCLK) disable iff (RST)
      st_q == uoed_pkg::ST_RECV && RX_END && RX_CRC_OK && !stall_q && !accept_q
      |=> HS_VALID && HS_CODE == uoed_pkg::HS_NAK ##1 !HS_VALID;
   endproperty
   a_nak: assert property (p_nak)
      else $error("full buffer not answered with NAK");
   property p_toggle;
      @(posedge MCLK) disable iff (RST)
      done_now && !(WR && rec_hit(ADDR))
      |=> rec_q[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_TOGGLE]
          != $past(rec_q[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_TOGGLE]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle not flipped on completion");
   property p_flag;
      @(posedge MCLK) disable iff (RST)
      done_now |=> rec_q[cur_idx][sel_y_q ? uoed_pkg::OFS_YCNT : uoed_pkg::OFS_XCNT][uoed_pkg::BIT_NAK]
                   && XFER_DONE;
   endproperty
   a_flag: assert property (p_flag)
      else $error("valid flag not set on completion");
   property p_irq;
      @(posedge MCLK) disable iff (RST)
      XFER_IRQ |-> XFER_DONE && $past(rec_q[cur_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_IRQ_EN]);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt without enable or completion");
   property p_base_kept;
      @(posedge MCLK) disable iff (RST)
      done_now && !WR |=> $stable(rec_q[cur_idx][uoed_pkg::OFS_XBASE])
                          && $stable(rec_q[cur_idx][uoed_pkg::OFS_YBASE]);
   endproperty
   a_base_kept: assert property (p_base_kept)
      else $error("base address changed by transfer");
   property p_single;
      @(posedge MCLK) disable iff (RST)
      tok_ok && !rec_q[tok_idx][uoed_pkg::OFS_CFG][uoed_pkg::BIT_DOUBLE_BUFFER_ENABLE] |=> !sel_y_q || st_q == uoed_pkg::ST_IDLE;
   endproperty
   a_single: assert property (p_single)
      else $error("Y buffer used without double buffering");
   property p_len;
      @(posedge MCLK) disable iff (RST)
      XFER_DONE |-> $past(cnt_q) <= uoed_pkg::MAX_COUNT;
   endproperty
   a_len: assert property (p_len)
      else $error("stored length above 64");

   c_stall: cover property (@(posedge MCLK) HS_VALID && HS_CODE == uoed_pkg::HS_STALL);
   c_nak:   cover property (@(posedge MCLK) HS_VALID && HS_CODE == uoed_pkg::HS_NAK);
   c_done:  cover property (@(posedge MCLK) XFER_DONE && XFER_IRQ);
   c_y:     cover property (@(posedge MCLK) done_now && sel_y_q);
endmodule : uoed_top
`default_nettype wire
